// >>> dpt_timebase.sv
// dual pwm timer timebase: two 8-bit timers, two 10-bit pwm outputs, wishbone slave
//
// Notes on behaviour
// - first output period from first timer
// - select bit picks second output's time base
// - duty is high byte plus low bits 7:6
// - output high for duty oscillator periods when the timer runs on the internal clock
// - zero duty keeps output low
// - high byte equal period: short low tail
// - high byte above period: full duty
// - duty writes buffered, loaded at rollover
// - duty reads return active slave latches
// - rollover sets flag, starts pwm period
// - flags stay set until software clears
// - external clock sampled once per instruction
// - enabled output overrides port pin and direction
// - timer counts to period then wraps
// - stopped timer neither counts nor flags
// - external clock counts synchronized falling edges
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module dpt_timebase (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic shared_ext_timer_clock_i,
  input wire logic [1:0] port_out_i,
  input wire logic [1:0] port_oe_i,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe_o
);
  import dpt_pkg::*;
  `include "dpt_map.svh"

  localparam int TCY_CYC = `DPT_TCY_NS / `DPT_TOSC_NS;
  localparam dpt_phase_t PH_LAST = 2'(TCY_CYC - 1);
  localparam dpt_byte_t IX_FIRST_TIMER = `DPT_BANK2 + `DPT_OFS_TMR_ONE;
  localparam dpt_byte_t IX_PER1 = `DPT_BANK2 + `DPT_OFS_PER_ONE;
  localparam dpt_byte_t IX_FLAGS = `DPT_BANK1 + `DPT_OFS_IRQ_FLAGS;
  localparam dpt_byte_t IX_IEN = `DPT_BANK1 + `DPT_OFS_IRQ_EN;
  localparam dpt_byte_t IX_D1LO = `DPT_BANK3 + `DPT_OFS_DUTY1_LO;
  localparam dpt_byte_t IX_D2LO = `DPT_BANK3 + `DPT_OFS_DUTY2_LO;
  localparam dpt_byte_t IX_D1HI = `DPT_BANK3 + `DPT_OFS_DUTY1_HI;
  localparam dpt_byte_t IX_D2HI = `DPT_BANK3 + `DPT_OFS_DUTY2_HI;
  localparam dpt_byte_t IX_CFG = `DPT_BANK3 + `DPT_OFS_CLK_CFG;
  localparam dpt_byte_t IX_RUN = `DPT_BANK3 + `DPT_OFS_RUN_CTL;

  // bus and register state
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  dpt_byte_t idx;
  logic wr_en;
  dpt_byte_t wbyte;
  dpt_byte_t rd_byte;
  dpt_byte_t ien_reg;
  dpt_byte_t cfg_reg;
  logic [5:0] run_reg;
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic sel_reg;
  dpt_duty_t master1_reg;
  dpt_duty_t master2_reg;
  logic [1:0][7:0] count_reg;
  logic [1:0][7:0] period_reg;

  // instruction-cycle phase and external clock path
  dpt_phase_t phase_reg;
  logic tick;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_smp_reg;
  logic ext_fall;

  // timer control
  logic [1:0] tmr_on;
  logic [1:0] tmr_cs;
  logic [1:0] inc;
  logic [1:0] wrap;
  logic [1:0] cnt_wr;
  logic [1:0] per_wr;

  // pwm channels
  dpt_duty_t active1;
  dpt_duty_t active2;
  logic first_pulse_output;
  logic second_pulse_output;
  logic load2;
  dpt_byte_t count2;
  logic [1:0] pwm_en;
  logic [1:0] pin_next;
  logic [1:0] oe_next;

  // bus decode: ack is registered, a write lands on the edge the master sees ack
  assign idx = adr_i[9:2];
  assign wbyte = dat_i[7:0];
  assign wr_en = cyc_i & stb_i & we_i & ack_reg & sel_i[0];
  assign ack_next = cyc_i & stb_i & ~ack_reg;

  // duty reads show the slave latches, not what was just written
  assign rd_byte =
    (idx == IX_FIRST_TIMER) ? count_reg[0] :
    (idx == IX_FIRST_TIMER + 8'h01) ? count_reg[1] :
    (idx == IX_PER1) ? period_reg[0] :
    (idx == IX_PER1 + 8'h01) ? period_reg[1] :
    (idx == IX_FLAGS) ? {2'b00, flag_reg, 4'h0} :
    (idx == IX_IEN) ? ien_reg :
    (idx == IX_D1LO) ? {active1[1:0], 6'h00} :
    (idx == IX_D2LO) ? {active2[1:0], sel_reg, 5'h00} :
    (idx == IX_D1HI) ? active1[9:2] :
    (idx == IX_D2HI) ? active2[9:2] :
    (idx == IX_CFG) ? cfg_reg :
    (idx == IX_RUN) ? {2'b00, run_reg} :
    8'h00;
  assign dat_next = (cyc_i & stb_i & ~we_i & ~ack_reg) ? {24'h000000, rd_byte} : dat_reg;

  // wishbone answer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // control registers; capture overflow bits 7:6 of run control are not held here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_reg <= `DPT_RST_IRQ_EN;
      cfg_reg <= `DPT_RST_CLK_CFG;
      run_reg <= 6'(`DPT_RST_RUN_CTL);
      sel_reg <= 1'b0;
    end else if (wr_en) begin
      if (idx == IX_IEN) ien_reg <= wbyte;
      if (idx == IX_CFG) cfg_reg <= wbyte;
      if (idx == IX_RUN) run_reg <= wbyte[5:0];
      if (idx == IX_D2LO) sel_reg <= wbyte[`DPT_DL_SEL];
    end
  end

  // master latches: full 10-bit duty from high byte and low bits 7:6
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master1_reg <= `DPT_RST_DUTY;
      master2_reg <= `DPT_RST_DUTY;
    end else if (wr_en) begin
      if (idx == IX_D1HI) master1_reg[9:2] <= wbyte;
      if (idx == IX_D1LO) master1_reg[1:0] <= wbyte[7:6];
      if (idx == IX_D2HI) master2_reg[9:2] <= wbyte;
      if (idx == IX_D2LO) master2_reg[1:0] <= wbyte[7:6];
    end
  end

  // instruction cycle is four oscillator periods; tick marks its last quarter
  assign tick = (phase_reg == PH_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= tick ? 2'h0 : phase_reg + 2'h1;
    end
  end

  // pin synchroniser, then one sample per instruction cycle
  // jitter of up to one instruction cycle is the price of sampling this slowly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      ext_smp_reg <= 1'b1;
    end else begin
      ext_s1_reg <= shared_ext_timer_clock_i;
      ext_s2_reg <= ext_s1_reg;
      if (tick) ext_smp_reg <= ext_s2_reg;
    end
  end

  assign ext_fall = tick & ext_smp_reg & ~ext_s2_reg;

  assign tmr_on = {run_reg[`DPT_RUN_ON2], run_reg[`DPT_RUN_ON1]};
  assign tmr_cs = {cfg_reg[`DPT_CFG_CS2], cfg_reg[`DPT_CFG_CS1]};

  // the combine bit is held for software only; pwm use forbids combining the timers
  generate
    for (genvar t = 0; t < 2; t++) begin : g_tmr
      assign inc[t] = tmr_on[t] & (tmr_cs[t] ? ext_fall : tick);
      // a count written by software cancels the rollover of that cycle
      assign wrap[t] = inc[t] & (count_reg[t] == period_reg[t]) & ~cnt_wr[t];
      assign cnt_wr[t] = wr_en & (idx == IX_FIRST_TIMER + 8'(t));
      assign per_wr[t] = wr_en & (idx == IX_PER1 + 8'(t));
      // set wins over a software clear in the same cycle
      assign flag_next[t] = wrap[t] |
        ((wr_en & (idx == IX_FLAGS)) ? wbyte[`DPT_FLAG_T1 + t] : flag_reg[t]);

      // counter: software write wins over an increment
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          count_reg[t] <= `DPT_RST_COUNT;
          period_reg[t] <= `DPT_RST_PERIOD;
          flag_reg[t] <= 1'b0;
        end else begin
          if (cnt_wr[t]) begin
            count_reg[t] <= wbyte;
          end else if (inc[t]) begin
            count_reg[t] <= wrap[t] ? 8'h00 : count_reg[t] + 8'h01;
          end
          if (per_wr[t]) period_reg[t] <= wbyte;
          flag_reg[t] <= flag_next[t];
        end
      end
    end
  endgenerate

  // second output follows either timer; the first always uses the first
  assign load2 = sel_reg ? wrap[1] : wrap[0];
  assign count2 = sel_reg ? count_reg[1] : count_reg[0];

  dpt_pwm_chan u_chan1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_i(phase_reg),
    .count_i(count_reg[0]),
    .load_i(wrap[0]),
    .master_i(master1_reg),
    .active_o(active1),
    .pwm_o(first_pulse_output)
  );

  dpt_pwm_chan u_chan2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_i(phase_reg),
    .count_i(count2),
    .load_i(load2),
    .master_i(master2_reg),
    .active_o(active2),
    .pwm_o(second_pulse_output)
  );

  // an enabled pwm takes the pin and forces it to drive
  assign pwm_en = {run_reg[`DPT_RUN_EN2], run_reg[`DPT_RUN_EN1]};
  assign pin_next = {pwm_en[1] ? second_pulse_output : port_out_i[1], pwm_en[0] ? first_pulse_output : port_out_i[0]};
  assign oe_next = pwm_en | port_oe_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 2'b00;
      pin_oe_o <= 2'b00;
    end else begin
      pin_o <= pin_next;
      pin_oe_o <= oe_next;
    end
  end

  // period start, flag and timer checks
  flag_on_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap[0] |=> flag_reg[0])
    else $error("rollover did not set first flag");
  flag_held_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_reg[1] && !(wr_en && idx == IX_FLAGS) |=> flag_reg[1])
    else $error("second flag dropped without clear");
  timer_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tmr_on[0] && !cnt_wr[0] |=> $stable(count_reg[0]) && !$rose(flag_reg[0]))
    else $error("stopped timer moved or flagged");
  timer_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inc[1] && count_reg[1] == period_reg[1] && !cnt_wr[1] |=> count_reg[1] == 8'h00)
    else $error("timer did not wrap at period");
  inc_on_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inc[0] |-> phase_reg == PH_LAST)
    else $error("timer moved off the instruction tick");
  tick_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick |=> !tick [*3] ##1 tick)
    else $error("instruction cycle not four clocks");
  duty_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !we_i && !ack_reg && idx == IX_D1HI |=> dat_o[7:0] == $past(active1[9:2]))
    else $error("duty read not from slave latch");
  pin_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_en[1] |=> pin_oe_o[1] && pin_o[1] == $past(second_pulse_output))
    else $error("enabled pwm did not own the pin");
  base_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_reg && wrap[1] && master2_reg != 10'h000 |=> active2 == $past(master2_reg))
    else $error("second output ignored second timer");

  // stopped second timer, flags and counting of the first timer
  flag_two_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap[1] |=> flag_reg[1])
    else $error("rollover did not set second flag");
  flag_one_held_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_reg[0] && !(wr_en && idx == IX_FLAGS) |=> flag_reg[0])
    else $error("first flag dropped without clear");
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && idx == IX_FLAGS && !wbyte[`DPT_FLAG_T1] && !wrap[0] |=> !flag_reg[0])
    else $error("first flag ignored a software clear");
  timer_two_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tmr_on[1] && !cnt_wr[1] |=> $stable(count_reg[1]) && !$rose(flag_reg[1]))
    else $error("stopped second timer moved or flagged");
  timer_one_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inc[0] && count_reg[0] == period_reg[0] && !cnt_wr[0] |=> count_reg[0] == 8'h00)
    else $error("first timer did not wrap at period");
  timer_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inc[0] && count_reg[0] != period_reg[0] && !cnt_wr[0]
      |=> count_reg[0] == $past(count_reg[0]) + 8'h01)
    else $error("first timer did not count up");
  ext_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_cs[0] && !ext_fall && !cnt_wr[0] |=> $stable(count_reg[0]))
    else $error("first timer moved without an external falling edge");

  // time base of each output and ownership of the pins
  base_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !sel_reg && wrap[0] |=> active2 == $past(master2_reg))
    else $error("second output ignored first timer");
  base_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_reg && wrap[1] && !wrap[0] |=> active1 == $past(active1))
    else $error("first output followed second timer");
  pin_take_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_en[0] |=> pin_oe_o[0] && pin_o[0] == $past(first_pulse_output))
    else $error("enabled first pwm did not own the pin");
  pin_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwm_en[0]
      |=> pin_o[0] == $past(port_out_i[0]) && pin_oe_o[0] == $past(port_oe_i[0]))
    else $error("disabled pwm did not leave the pin to the port");
  duty_low_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !we_i && !ack_reg && idx == IX_D2LO
      |=> dat_o[7:0] == {$past(active2[1:0]), $past(sel_reg), 5'h00})
    else $error("duty low read not from slave latch");
endmodule // dpt_timebase

// >>> dpt_map.svh
// register map, field positions, reset values and timing of the dual pwm timebase
`ifndef DPT_MAP_SVH
`define DPT_MAP_SVH

// oscillator period and instruction cycle, in ns
`define DPT_TOSC_NS 40
`define DPT_TCY_NS 160

// bank bases, added to the printed offsets to form the word index
`define DPT_BANK1 8'h20
`define DPT_BANK2 8'h40
`define DPT_BANK3 8'h60

// printed offsets
`define DPT_OFS_TMR_ONE 8'h10
`define DPT_OFS_TMR_TWO 8'h11
`define DPT_OFS_PER_ONE 8'h14
`define DPT_OFS_PER_TWO 8'h15
`define DPT_OFS_DUTY1_LO 8'h10
`define DPT_OFS_DUTY2_LO 8'h11
`define DPT_OFS_DUTY1_HI 8'h12
`define DPT_OFS_DUTY2_HI 8'h13
`define DPT_OFS_IRQ_FLAGS 8'h16
`define DPT_OFS_IRQ_EN 8'h17
`define DPT_OFS_CLK_CFG 8'h16
`define DPT_OFS_RUN_CTL 8'h17

// field positions
`define DPT_FLAG_T1 4
`define DPT_FLAG_T2 5
`define DPT_CFG_CS1 0
`define DPT_CFG_CS2 1
`define DPT_CFG_COMBINE 3
`define DPT_RUN_ON1 0
`define DPT_RUN_ON2 1
`define DPT_RUN_EN1 4
`define DPT_RUN_EN2 5
`define DPT_DL_SEL 5

// reset values
`define DPT_RST_IRQ_FLAGS 8'h02
`define DPT_RST_IRQ_EN 8'h00
`define DPT_RST_CLK_CFG 8'h00
`define DPT_RST_RUN_CTL 8'h00
`define DPT_RST_DUTY 10'h000
`define DPT_RST_COUNT 8'h00
`define DPT_RST_PERIOD 8'hff

`endif

// >>> dpt_pkg.sv
// shared types of the dual pwm timebase
package dpt_pkg;
  typedef logic [9:0] dpt_duty_t;
  typedef logic [7:0] dpt_byte_t;
  typedef logic [1:0] dpt_phase_t;
endpackage

// >>> dpt_pwm_chan.sv
// one pwm channel: double-buffered duty and quarter-cycle compare
`timescale 1ns/1ps
module dpt_pwm_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dpt_pkg::dpt_phase_t phase_i,
  input wire dpt_pkg::dpt_byte_t count_i,
  input wire logic load_i,
  input wire dpt_pkg::dpt_duty_t master_i,
  output dpt_pkg::dpt_duty_t active_o,
  output logic pwm_o
);
  import dpt_pkg::*;
  `include "dpt_map.svh"

  dpt_duty_t active_reg;
  logic pwm_reg;
  logic pwm_next;
  dpt_duty_t position;
  dpt_duty_t next_pos;
  logic reach;

  // position in quarter-cycle steps; the high part ends as the next step meets the duty,
  // so with the timer on the internal clock the output stays high for exactly duty oscillator periods
  assign position = {count_i, phase_i};
  assign next_pos = position + 10'h001;
  assign reach = (next_pos == active_reg);
  // a zero duty loads a low output; a duty past the period only meets the rollover,
  // where the load wins and keeps the output high
  assign pwm_next = load_i ? (master_i != 10'h000) : (reach ? 1'b0 : pwm_reg);

  // slave latch copies master only at the period start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= `DPT_RST_DUTY;
      pwm_reg <= 1'b0;
    end else begin
      if (load_i) begin
        active_reg <= master_i;
      end
      pwm_reg <= pwm_next;
    end
  end

  assign active_o = active_reg;
  assign pwm_o = pwm_reg;

  slave_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_i |=> active_reg == $past(master_i))
    else $error("slave latch did not take master value");
  start_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_i && master_i != 10'h000 |=> pwm_reg)
    else $error("output not high at period start");
  zero_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_i && master_i == 10'h000 |=> !pwm_reg)
    else $error("zero duty output went high");
  duty_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_reg && next_pos == active_reg && !load_i |=> !pwm_reg)
    else $error("output stayed high past duty");
endmodule // dpt_pwm_chan

// >>> testbench.sv
// self-checking bench for the dual pwm timebase, with a behavioural duty model
`timescale 1ns/1ps
module testbench;
  import dpt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic ext_clk = 1'b1;
  logic [1:0] port_out = 2'h0;
  logic [1:0] port_oe = 2'h0;
  logic [1:0] pin_o;
  logic [1:0] pin_oe_o;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int exp_q[$];
  int p1 = 7;
  int p2 = 4;
  int hi, lo, cnt;

  dpt_timebase dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .shared_ext_timer_clock_i(ext_clk), .port_out_i(port_out), .port_oe_i(port_oe),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o));

  // 25 mhz oscillator
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("mismatches %0d of %0d comparisons", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, about ten times the two thousand cycles the sequence needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic wishbone cycle; ack and read data are taken at the same edge
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hf;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 64);
    check({31'h0, ack_o}, 32'h1);
    q = dat_o[7:0];
    if (!w) check({8'h00, dat_o[31:8]}, 32'h0);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    check({24'h0, q}, {24'h0, exp});
  endtask

  // model: high clocks per period of 4*(p+1) oscillator clocks
  function automatic int exp_high(input int p, input int h, input int l);
    if (h > p) return 4 * (p + 1);
    return h * 4 + l;
  endfunction

  // counting over exactly one period length is independent of phase
  task automatic meas(input int ch, input int p, output int c);
    c = 0;
    repeat (4 * (p + 1)) begin
      @(posedge clk_i);
      if (pin_o[ch] === 1'b1) c++;
    end
  endtask

  initial begin
    void'($urandom(92));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset state of control registers and an unmapped place
    rd(8'h36, 8'h00);
    rd(8'h37, 8'h00);
    rd(8'h76, 8'h00);
    rd(8'h77, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    wr(8'h37, 8'h5a);
    rd(8'h37, 8'h5a);
    // pwm disabled: pins follow normal port control
    @(posedge clk_i);
    port_out <= 2'($urandom);
    port_oe <= 2'($urandom);
    repeat (3) @(posedge clk_i);
    check({30'h0, pin_o}, {30'h0, port_out});
    check({30'h0, pin_oe_o}, {30'h0, port_oe});
    // timers stopped: a duty write stays in the master latch
    wr(8'h72, 8'h33);
    rd(8'h72, 8'h00);
    wr(8'h54, 8'(p1));
    wr(8'h55, 8'(p2));
    wr(8'h77, 8'h33);
    repeat (8 * (p1 + 1)) @(posedge clk_i);
    rd(8'h72, 8'h33);
    // first output: zero, equal-to-period with every low pair, above period, random
    for (int i = 0; i < 8; i++) begin
      hi = (i == 0) ? 0 : (i < 5) ? p1 : (i == 5) ? p1 + 1 : 1 + $urandom % (p1 - 1);
      lo = (i > 0 && i < 5) ? i - 1 : (i > 5) ? $urandom % 4 : 0;
      exp_q.push_back(exp_high(p1, hi, lo));
      wr(8'h72, 8'(hi));
      wr(8'h70, 8'(lo << 6));
      repeat (12 * (p1 + 1)) @(posedge clk_i);
      meas(0, p1, cnt);
      check(cnt, exp_q.pop_front());
      check({31'h0, pin_oe_o[0]}, 32'h1);
      rd(8'h70, 8'(lo << 6));
    end
    // second output on either time base, duty above the shorter period only
    for (int s = 0; s < 2; s++) begin
      wr(8'h73, 8'h05);
      wr(8'h71, 8'(8'h80 | (s << 5)));
      repeat (12 * (p1 + 1)) @(posedge clk_i);
      meas(1, (s == 1) ? p2 : p1, cnt);
      check(cnt, (s == 1) ? exp_high(p2, 5, 2) : exp_high(p1, 5, 2));
      check({31'h0, pin_oe_o[1]}, 32'h1);
    end
    // both timers rolled over: flags latched until cleared
    rd(8'h36, 8'h30);
    wr(8'h77, 8'h30);
    wr(8'h36, 8'h00);
    repeat (100) @(posedge clk_i);
    rd(8'h36, 8'h00);
    // external clock: duty low bits cleared, combine bit clear, five slow falling edges
    wr(8'h70, 8'h00);
    wr(8'h50, 8'h00);
    wr(8'h76, 8'h01);
    wr(8'h77, 8'h31);
    repeat (5) begin
      repeat (16) @(posedge clk_i);
      ext_clk <= 1'b0;
      repeat (16) @(posedge clk_i);
      ext_clk <= 1'b1;
    end
    wr(8'h77, 8'h30);
    rd(8'h50, 8'h05);
    final_report();
  end
endmodule // testbench
